// ### hdl/flux_balance_duty_adjust.sv
// Flux balance duty correction with register port and telemetry source control
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Source select shows code 3 (slow converter) while not switching.
// - Source select shows code 0 (fast rectifier sense) while switching.
// - Correction drives odd and even half-cycle volt-seconds toward equality.
// - Voltage is measured from the rectifier sense input, pulse width from the i_pulse_on input.
// - Odd minus even error feeds a PI compensator giving duty correction.
// - Voltage select 1 balances using measured odd and even voltages only.
// - Voltage select 0 with timing-only 1 balances pulse widths only.
// - Both selects 0 gives full volt-second balance.
// - Correction limited to max setting, LSB 2^-10 of period, up to 24.902 percent.
// - Max setting of zero blocks every balancing adjustment.
// - Proportional gain is (8+bits[2:0]) times 2^(bits[5:3]-18).
// - Integral gain is (8+bits[2:0]) times 2^(bits[5:3]-22).
// - Proportional path scales present error with no memory.
// - Integral path sums the error each cycle, scaled by integral gain.
// - Fault raised when error magnitude exceeds threshold, 2 V-us per step.
// - Light-load threshold 0.5 A per step; index 63 disables the feature.
// - Light-load entry and exit need a run of 1 to 4 samples.
// - At light load, select 0 freezes correction, select 1 forces zero.
module flux_balance_duty_adjust
    import flux_balance_pkg::*;
(
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst,
    input  wire logic [ADDR_W-1:0]        i_addr,
    input  wire logic [DATA_W-1:0]        i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic [DATA_W-1:0]             o_rdata,
    input  wire logic                     i_switching,
    input  wire logic                     i_sample_valid,
    input  wire logic [VOLT_W-1:0]        i_rect_voltage,
    input  wire logic                     i_pulse_on,
    input  wire logic                     i_half_end,
    input  wire logic                     i_half_odd,
    input  wire logic                     i_current_valid,
    input  wire logic [CUR_W-1:0]         i_load_current,
    output logic signed [CORR_W-1:0]      o_duty_correction,
    output logic                          o_correction_valid,
    output logic                          o_balance_fault,
    output logic                          o_light_load,
    output logic [1:0]                    o_vin_source_select
);
    logic [2:0]              mode_q, mode_d;
    logic [7:0]              max_q, max_d;
    logic [5:0]              prop_q, prop_d;
    logic [5:0]              integ_q, integ_d;
    logic [7:0]              fth_q, fth_d;
    logic [5:0]              lth_q, lth_d;
    logic [RUN_W-1:0]        dis_q, dis_d;
    logic [RUN_W-1:0]        ena_q, ena_d;
    logic                    sticky_q, sticky_d;
    logic [DATA_W-1:0]       rdata_d;
    logic [1:0]              src_d;

    logic                    meas_valid;
    logic [1:0][VS_W-1:0]    vs;
    logic [1:0][CNT_W-1:0]   width;
    logic [1:0][VOLT_W-1:0]  volt;

    bal_mode_t               mode;
    logic signed [ERR_W-1:0] err_q, err_d;
    logic                    err_valid_q;
    logic [ERR_W-1:0]        err_mag;
    logic                    fault_d;

    light_state_t            ll_q, ll_d;
    logic [RUN_W-1:0]        run_q, run_d;
    logic                    below;

    pi_if bus();

    half_cycle_meter u_meter (
        .i_mclk         (i_mclk),
        .i_rst          (i_rst),
        .i_sample_valid (i_sample_valid),
        .i_volt         (i_rect_voltage),
        .i_pulse_on     (i_pulse_on),
        .i_half_end     (i_half_end),
        .i_half_odd     (i_half_odd),
        .o_meas_valid   (meas_valid),
        .o_vs           (vs),
        .o_width        (width),
        .o_volt         (volt)
    );

    balance_pi u_pi (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .bus    (bus)
    );

    // Register writes and fault sticky bit
    always_comb
    begin
        mode_d   = mode_q;
        max_d    = max_q;
        prop_d   = prop_q;
        integ_d  = integ_q;
        fth_d    = fth_q;
        lth_d    = lth_q;
        dis_d    = dis_q;
        ena_d    = ena_q;
        sticky_d = sticky_q;
        if (i_wr)
        begin
            case (i_addr)
                REG_MODE:     mode_d  = i_wdata[2:0];
                REG_MAX:      max_d   = i_wdata[7:0];
                REG_COEFF:
                begin
                    prop_d  = i_wdata[5:0];
                    integ_d = i_wdata[COEFF_INTEG_LSB +: 6];
                end
                REG_FAULT_TH: fth_d   = i_wdata[7:0];
                REG_LIGHT:
                begin
                    lth_d = i_wdata[5:0];
                    dis_d = i_wdata[LIGHT_DIS_LSB +: RUN_W];
                    ena_d = i_wdata[LIGHT_ENA_LSB +: RUN_W];
                end
                REG_STATUS:
                    if (i_wdata[STAT_FAULT_BIT])
                        sticky_d = 1'b0;
                default: ;
            endcase
        end
        // A fault in the clearing cycle is kept
        if (fault_d)
            sticky_d = 1'b1;
    end

    always_comb
    begin
        rdata_d = '0;
        if (i_rd)
        begin
            case (i_addr)
                REG_MODE:     rdata_d = DATA_W'(mode_q);
                REG_MAX:      rdata_d = DATA_W'(max_q);
                REG_COEFF:    rdata_d = DATA_W'({2'h0, integ_q, 2'h0, prop_q});
                REG_FAULT_TH: rdata_d = DATA_W'(fth_q);
                REG_LIGHT:    rdata_d = DATA_W'({2'h0, ena_q, 2'h0, dis_q, 2'h0, lth_q});
                REG_STATUS:   rdata_d = DATA_W'({o_vin_source_select, o_light_load, sticky_q});
                REG_CORR:     rdata_d = DATA_W'($signed(o_duty_correction));
                default:      rdata_d = '0;
            endcase
        end
    end

    // Error selection by balance mode
    always_comb
    begin
        if (mode_q[MODE_VOLT_BIT])
            mode = BAL_VOLT;
        else if (mode_q[MODE_TIME_BIT])
            mode = BAL_TIME;
        else
            mode = BAL_FULL;
        case (mode)
            BAL_VOLT: err_d = ERR_W'(volt[1]) - ERR_W'(volt[0]);
            BAL_TIME: err_d = ERR_W'(width[1]) - ERR_W'(width[0]);
            BAL_FULL: err_d = ERR_W'(vs[1]) - ERR_W'(vs[0]);
            default:  err_d = '0;
        endcase
        err_mag = err_q[ERR_W-1] ? ERR_W'(-err_q) : ERR_W'(err_q);
        fault_d = err_valid_q && (err_mag > (ERR_W'(fth_q) << FAULT_SHIFT));
    end

    // Light-load detection with run filters
    always_comb
    begin
        ll_d  = ll_q;
        run_d = run_q;
        below = i_load_current < CUR_W'(lth_q);
        if (lth_q == LIGHT_OFF)
        begin
            ll_d  = LL_NORMAL;
            run_d = '0;
        end
        else if (i_current_valid)
        begin
            case (ll_q)
                LL_NORMAL:
                    if (!below)
                        run_d = '0;
                    else if (run_q == dis_q)
                    begin
                        ll_d  = LL_LIGHT;
                        run_d = '0;
                    end
                    else
                        run_d = run_q + RUN_W'(1);
                LL_LIGHT:
                    if (below)
                        run_d = '0;
                    else if (run_q == ena_q)
                    begin
                        ll_d  = LL_NORMAL;
                        run_d = '0;
                    end
                    else
                        run_d = run_q + RUN_W'(1);
                default:
                begin
                    ll_d  = LL_NORMAL;
                    run_d = '0;
                end
            endcase
        end
        src_d = i_switching ? SRC_FAST : SRC_SLOW;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            mode_q              <= MODE_RST;
            max_q               <= MAX_RST;
            prop_q              <= PROP_RST;
            integ_q             <= INTEG_RST;
            fth_q               <= FAULT_TH_RST;
            lth_q               <= LIGHT_TH_RST;
            dis_q               <= RUN_RST;
            ena_q               <= RUN_RST;
            sticky_q            <= 1'b0;
            o_rdata             <= '0;
            err_q               <= '0;
            err_valid_q         <= 1'b0;
            o_balance_fault     <= 1'b0;
            ll_q                <= LL_NORMAL;
            run_q               <= '0;
            o_light_load        <= 1'b0;
            o_vin_source_select <= SRC_SLOW;
            o_duty_correction   <= '0;
            o_correction_valid  <= 1'b0;
        end
        else
        begin
            mode_q              <= mode_d;
            max_q               <= max_d;
            prop_q              <= prop_d;
            integ_q             <= integ_d;
            fth_q               <= fth_d;
            lth_q               <= lth_d;
            dis_q               <= dis_d;
            ena_q               <= ena_d;
            sticky_q            <= sticky_d;
            o_rdata             <= rdata_d;
            err_q               <= meas_valid ? err_d : err_q;
            err_valid_q         <= meas_valid;
            o_balance_fault     <= err_valid_q ? fault_d : o_balance_fault;
            ll_q                <= ll_d;
            run_q               <= run_d;
            o_light_load        <= (ll_d == LL_LIGHT);
            o_vin_source_select <= src_d;
            o_duty_correction   <= bus.corr;
            o_correction_valid  <= bus.corr_valid;
        end
    end

    assign bus.err       = err_q;
    assign bus.err_valid = err_valid_q;
    assign bus.prop      = prop_q;
    assign bus.integ     = integ_q;
    assign bus.max       = max_q;
    assign bus.light     = (ll_q == LL_LIGHT);
    assign bus.zero_sel  = mode_q[MODE_ZERO_BIT];

    AST_SRC_SLOW: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_switching |=> o_vin_source_select == SRC_SLOW)
        else $error("slow source not selected while idle");

    AST_SRC_FAST: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_switching |=> o_vin_source_select == SRC_FAST)
        else $error("fast source not selected while switching");

    AST_FAULT: assert property (@(posedge i_mclk) disable iff (i_rst)
        fault_d |=> o_balance_fault && sticky_q)
        else $error("fault not raised");

    AST_RDATA_IDLE: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_rd |=> o_rdata == '0)
        else $error("read data outside the read answer cycle");

    AST_TIME_MODE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (meas_valid && !mode_q[MODE_VOLT_BIT] && mode_q[MODE_TIME_BIT])
        |=> err_q == ERR_W'($past(width[1])) - ERR_W'($past(width[0])))
        else $error("timing-only error wrong");

    AST_LL_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
        (lth_q == LIGHT_OFF) |=> !o_light_load)
        else $error("light load active although disabled");

endmodule

// ### hdl/flux_balance_pkg.sv
// Constants, register map and helper functions shared by the flux balance design
package flux_balance_pkg;

    localparam int VOLT_W   = 11;
    localparam int CNT_W    = 12;
    localparam int VS_W     = VOLT_W + CNT_W;
    localparam int ERR_W    = 24;
    localparam int ACC_W    = 28;
    localparam int PROD_W   = 40;
    localparam int CORR_W   = 9;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 16;
    localparam int CUR_W    = 8;
    localparam int RUN_W    = 2;

    // Register word indices
    localparam logic [ADDR_W-1:0] REG_MODE     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MAX      = 4'h1;
    localparam logic [ADDR_W-1:0] REG_COEFF    = 4'h2;
    localparam logic [ADDR_W-1:0] REG_FAULT_TH = 4'h3;
    localparam logic [ADDR_W-1:0] REG_LIGHT    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CORR     = 4'h6;

    // Field positions
    localparam int MODE_VOLT_BIT   = 0;
    localparam int MODE_TIME_BIT   = 1;
    localparam int MODE_ZERO_BIT   = 2;
    localparam int COEFF_INTEG_LSB = 8;
    localparam int LIGHT_DIS_LSB   = 8;
    localparam int LIGHT_ENA_LSB   = 12;
    localparam int STAT_FAULT_BIT  = 0;
    localparam int STAT_LIGHT_BIT  = 1;
    localparam int STAT_SRC_LSB    = 2;

    // Reset values
    localparam logic [2:0] MODE_RST     = 3'h4;
    localparam logic [7:0] MAX_RST      = 8'h14;
    localparam logic [5:0] PROP_RST     = 6'h08;
    localparam logic [5:0] INTEG_RST    = 6'h1E;
    localparam logic [7:0] FAULT_TH_RST = 8'hFF;
    localparam logic [5:0] LIGHT_TH_RST = 6'h3F;
    localparam logic [1:0] RUN_RST      = 2'h1;

    // Input-voltage telemetry source codes
    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h3;

    localparam int          PROP_SHIFT  = 18;
    localparam int          INTEG_SHIFT = 22;
    localparam logic [3:0]  MANT_BASE   = 4'h8;
    localparam logic [5:0]  LIGHT_OFF   = 6'h3F;
    localparam int          FAULT_SHIFT = 1;

    typedef enum logic [1:0] {BAL_FULL, BAL_TIME, BAL_VOLT} bal_mode_t;
    typedef enum logic {LL_NORMAL, LL_LIGHT} light_state_t;

    function automatic logic [3:0] coeff_mant(input logic [5:0] idx);
        return MANT_BASE + {1'b0, idx[2:0]};
    endfunction

    function automatic logic [2:0] coeff_exp(input logic [5:0] idx);
        return idx[5:3];
    endfunction

endpackage

// ### hdl/pi_if.sv
// Link between the balance controller and its PI compensator
`timescale 1ns/1ps
interface pi_if;
    import flux_balance_pkg::*;
    logic signed [ERR_W-1:0]  err;
    logic                     err_valid;
    logic [5:0]               prop;
    logic [5:0]               integ;
    logic [7:0]               max;
    logic                     light;
    logic                     zero_sel;
    logic signed [CORR_W-1:0] corr;
    logic                     corr_valid;

    modport ctrl (output err, err_valid, prop, integ, max, light, zero_sel,
                  input corr, corr_valid);
    modport pi   (input err, err_valid, prop, integ, max, light, zero_sel,
                  output corr, corr_valid);
endinterface

// ### hdl/half_cycle_meter.sv
// Per half-cycle pulse width, volt-second and plateau voltage measurement
`timescale 1ns/1ps
module half_cycle_meter
    import flux_balance_pkg::*;
(
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    input  wire logic                      i_sample_valid,
    input  wire logic [VOLT_W-1:0]         i_volt,
    input  wire logic                      i_pulse_on,
    input  wire logic                      i_half_end,
    input  wire logic                      i_half_odd,
    output logic                           o_meas_valid,
    output logic [1:0][VS_W-1:0]           o_vs,
    output logic [1:0][CNT_W-1:0]          o_width,
    output logic [1:0][VOLT_W-1:0]         o_volt
);
    logic [VS_W-1:0]   vs_q,   vs_d;
    logic [CNT_W-1:0]  w_q,    w_d;
    logic [VOLT_W-1:0] v_q,    v_d;
    logic [VS_W-1:0]   vs_nx;
    logic [CNT_W-1:0]  w_nx;
    logic [VOLT_W-1:0] v_nx;
    logic              valid_d;

    always_comb
    begin
        vs_nx = vs_q;
        w_nx  = w_q;
        v_nx  = v_q;
        if (i_sample_valid && i_pulse_on)
        begin
            vs_nx = vs_q + VS_W'(i_volt);
            w_nx  = w_q + CNT_W'(1);
            v_nx  = i_volt;
        end
        vs_d    = i_half_end ? '0 : vs_nx;
        w_d     = i_half_end ? '0 : w_nx;
        v_d     = i_half_end ? '0 : v_nx;
        valid_d = i_half_end && !i_half_odd;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            vs_q         <= '0;
            w_q          <= '0;
            v_q          <= '0;
            o_meas_valid <= 1'b0;
        end
        else
        begin
            vs_q         <= vs_d;
            w_q          <= w_d;
            v_q          <= v_d;
            o_meas_valid <= valid_d;
        end
    end

    // Slot 1 holds the odd half, slot 0 the even half
    for (genvar g = 0; g < 2; g++)
    begin : g_slot
        logic take;
        assign take = i_half_end && (i_half_odd == (g == 1));
        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
            begin
                o_vs[g]    <= '0;
                o_width[g] <= '0;
                o_volt[g]  <= '0;
            end
            else if (take)
            begin
                o_vs[g]    <= vs_nx;
                o_width[g] <= w_nx;
                o_volt[g]  <= v_nx;
            end
        end
    end

    sequence seq_even_end;
        i_half_end && !i_half_odd;
    endsequence

    AST_CYCLE_CLOSE: assert property (@(posedge i_mclk) disable iff (i_rst)
        seq_even_end |=> o_meas_valid)
        else $error("measurement not emitted after even half end");

    AST_WIDTH_COUNT: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_sample_valid && i_pulse_on && !i_half_end) |=> w_q == $past(w_q) + CNT_W'(1))
        else $error("pulse width count did not advance");

endmodule

// ### hdl/balance_pi.sv
// PI compensator with symmetric limit and integrator hold
`timescale 1ns/1ps
module balance_pi
    import flux_balance_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst,
    pi_if.pi          bus
);
    logic signed [ACC_W-1:0]  acc_q, acc_d, acc_nx;
    logic signed [CORR_W-1:0] corr_q, corr_d;
    logic                     valid_q, valid_d;
    logic                     sat_hi_q, sat_hi_d, sat_lo_q, sat_lo_d;
    logic signed [PROD_W-1:0] sum, limit;
    logic                     hold;

    function automatic logic signed [PROD_W-1:0] apply_gain(
        input logic signed [ACC_W-1:0] v,
        input logic [5:0]              idx,
        input int                      sh);
        logic signed [PROD_W-1:0] prod;
        prod = PROD_W'(v) * $signed({1'b0, coeff_mant(idx)});
        prod = prod <<< coeff_exp(idx);
        return prod >>> sh;
    endfunction

    always_comb
    begin
        limit  = $signed({{(PROD_W-8){1'b0}}, bus.max});
        // Stop integrating further into a limit already hit
        hold   = (sat_hi_q && bus.err > 0) || (sat_lo_q && bus.err < 0);
        acc_nx = hold ? acc_q : acc_q + ACC_W'(bus.err);
        sum    = apply_gain(ACC_W'(bus.err), bus.prop, PROP_SHIFT)
               + apply_gain(acc_nx, bus.integ, INTEG_SHIFT);
        acc_d    = acc_q;
        corr_d   = corr_q;
        valid_d  = 1'b0;
        sat_hi_d = sat_hi_q;
        sat_lo_d = sat_lo_q;
        if (bus.light && bus.zero_sel)
            corr_d = '0;
        if (bus.err_valid)
        begin
            valid_d = 1'b1;
            if (bus.light)
            begin
                // Freeze keeps corr_q, zero select already cleared it
            end
            else if (bus.max == '0)
            begin
                corr_d   = '0;
                sat_hi_d = 1'b0;
                sat_lo_d = 1'b0;
            end
            else
            begin
                acc_d    = acc_nx;
                sat_hi_d = sum > limit;
                sat_lo_d = sum < -limit;
                if (sum > limit)
                    corr_d = CORR_W'(limit);
                else if (sum < -limit)
                    corr_d = CORR_W'(-limit);
                else
                    corr_d = CORR_W'(sum);
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            acc_q    <= '0;
            corr_q   <= '0;
            valid_q  <= 1'b0;
            sat_hi_q <= 1'b0;
            sat_lo_q <= 1'b0;
        end
        else
        begin
            acc_q    <= acc_d;
            corr_q   <= corr_d;
            valid_q  <= valid_d;
            sat_hi_q <= sat_hi_d;
            sat_lo_q <= sat_lo_d;
        end
    end

    assign bus.corr       = corr_q;
    assign bus.corr_valid = valid_q;

    AST_ZERO_MAX: assert property (@(posedge i_mclk) disable iff (i_rst)
        (bus.err_valid && bus.max == '0 && !bus.light) |=> corr_q == '0)
        else $error("correction not blocked by zero limit");

    AST_LIMIT: assert property (@(posedge i_mclk) disable iff (i_rst)
        (bus.err_valid && !bus.light) |=>
        ($signed({{(PROD_W-CORR_W){corr_q[CORR_W-1]}}, corr_q}) <= $past(limit)
         && $signed({{(PROD_W-CORR_W){corr_q[CORR_W-1]}}, corr_q}) >= -$past(limit)))
        else $error("correction outside limit");

    AST_WINDUP: assert property (@(posedge i_mclk) disable iff (i_rst)
        (bus.err_valid && !bus.light && sat_hi_q && bus.err > 0) |=> $stable(acc_q))
        else $error("integrator ran on while saturated");

    AST_FREEZE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (bus.light && !bus.zero_sel) |=> corr_q == $past(corr_q))
        else $error("frozen correction moved");

    AST_ZERO_LIGHT: assert property (@(posedge i_mclk) disable iff (i_rst)
        (bus.light && bus.zero_sel) |=> corr_q == '0)
        else $error("correction not zeroed at light load");

endmodule

// ### dv/bridge_sense_model.sv
// Full-bridge PWM and rectifier sense source, 32-cycle half periods
`timescale 1ns/1ps
module bridge_sense_model (
    input  wire logic        i_mclk,
    input  wire logic        i_run,
    input  wire logic [4:0]  i_odd_w,
    input  wire logic [4:0]  i_even_w,
    input  wire logic [10:0] i_volt,
    output logic             o_pulse_on,
    output logic [10:0]      o_volt,
    output logic             o_half_end,
    output logic             o_half_odd
);
    logic [4:0] cnt_q = 5'h00;
    logic       odd_q = 1'b1;
    always_ff @(posedge i_mclk)
    begin
        cnt_q <= i_run ? cnt_q + 5'h01 : 5'h00;
        odd_q <= i_run ? odd_q ^ (cnt_q == 5'h1F) : 1'b1;
    end
    assign o_pulse_on = i_run && (cnt_q < (odd_q ? i_odd_w : i_even_w));
    // Off-pulse samples show the inverse so a stale plateau cannot pass
    assign o_volt = o_pulse_on ? i_volt : ~i_volt;
    assign o_half_end = i_run && cnt_q == 5'h1F;
    assign o_half_odd = odd_q;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the flux balance duty adjuster
`timescale 1ns/1ps
module testbench;
    import flux_balance_pkg::*;
    logic i_mclk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic i_switching = 1'b0, run = 1'b0, pon, hend, hodd, fault;
    logic cur_v = 1'b0, light, cvalid;
    logic [7:0] cur = 8'h00;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic [4:0] odd_w = 5'h00, even_w = 5'h00;
    logic [10:0] volt;
    logic signed [8:0] corr;
    logic [1:0] src;
    int bad_count = 0, total_checks = 0;
    flux_balance_duty_adjust flux_balance_duty_adjust_inst (.i_mclk, .i_rst,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_switching,
        .i_sample_valid(run), .i_rect_voltage(volt), .i_pulse_on(pon),
        .i_half_end(hend), .i_half_odd(hodd), .i_current_valid(cur_v),
        .i_load_current(cur), .o_duty_correction(corr), .o_correction_valid(cvalid),
        .o_balance_fault(fault), .o_light_load(light), .o_vin_source_select(src));
    bridge_sense_model bridge_sense_model_inst (.i_mclk, .i_run(run),
        .i_odd_w(odd_w), .i_even_w(even_w), .i_volt(11'h3E8),
        .o_pulse_on(pon), .o_volt(volt), .o_half_end(hend), .o_half_odd(hodd));
    initial forever #5 i_mclk = ~i_mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic rst(input int n);
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (n) @(posedge i_mclk);
        i_rst <= 1'b0;
    endtask
    task automatic t_regs;
        rdchk(REG_MODE, 16'h0004);
        rdchk(REG_MAX, 16'h0014);
        rdchk(REG_COEFF, 16'h1E08);
        rdchk(REG_FAULT_TH, 16'h00FF);
        rdchk(REG_LIGHT, 16'h113F);
        rdchk(4'h7, 16'h0000);
        wr(REG_MAX, 16'h00A5);
        rdchk(REG_MAX, 16'h00A5);
        chk(16'(src), 16'h0003);
        $display("regs done");
    endtask
    task automatic t_src;
        @(posedge i_mclk);
        i_switching <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1 chk(16'(src), 16'h0000);
        @(posedge i_mclk);
        i_switching <= 1'b0;
        repeat (2) @(posedge i_mclk);
        #1 chk(16'(src), 16'h0003);
        $display("source done");
    endtask
    task automatic t_light;
        wr(REG_MODE, 16'h0000);
        wr(REG_LIGHT, 16'h0114);
        @(posedge i_mclk);
        cur_v <= 1'b1;
        cur <= 8'h0A;
        @(posedge i_mclk);
        #1 chk(16'(light), 16'h0000);
        @(posedge i_mclk);
        cur_v <= 1'b0;
        #1 chk(16'(light), 16'h0001);
        rdchk(REG_STATUS, 16'h000E);
        wr(REG_LIGHT, 16'h003F);
        @(posedge i_mclk);
        #1 chk(16'(light), 16'h0000);
        $display("light load done");
    endtask
    // Odd minus even error: a longer odd half gives a positive correction
    task automatic t_bal(input logic [15:0] md, mx, cf, input logic [4:0] ow, ew,
        input int pairs, input logic [15:0] ec, input logic ef);
        rst(2);
        wr(REG_MODE, md);
        wr(REG_MAX, mx);
        wr(REG_COEFF, cf);
        @(posedge i_mclk);
        odd_w <= ow;
        even_w <= ew;
        run <= 1'b1;
        repeat (pairs * 64) @(posedge i_mclk);
        #1 chk(16'(corr), ec);
        chk(16'(fault), 16'(ef));
        repeat (3) @(posedge i_mclk);
        #1 chk(16'(cvalid), 16'h0001);
        @(posedge i_mclk);
        #1 chk(16'(cvalid), 16'h0000);
        @(posedge i_mclk);
        run <= 1'b0;
        $display("balance case done");
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        rst(16);
        t_regs;
        t_src;
        t_light;
        t_bal(16'h4, 16'h4, 16'h1E08, 5'h10, 5'h10, 40, 16'h0, 1'b0);
        t_bal(16'h4, 16'h4, 16'h1E08, 5'h14, 5'h0C, 40, 16'h4, 1'b1);
        t_bal(16'h4, 16'h0, 16'h1E08, 5'h14, 5'h0C, 40, 16'h0, 1'b1);
        t_bal(16'h5, 16'h4, 16'h1E08, 5'h1C, 5'h04, 40, 16'h0, 1'b0);
        t_bal(16'h6, 16'h1, 16'h3F3F, 5'h1C, 5'h04, 120, 16'h1, 1'b0);
        final_report();
    end
    initial
    begin
        // The scenarios need about 18k cycles
        #300000;
        bad_count++;
        final_report();
    end
endmodule
